// file: rtl/bpp_pkg.sv
package bpp_pkg;

  localparam int NPORT = 8;

  // Register indices; the bus byte address is four times the index.
  localparam logic [11:0] IDX_P1        = 12'h002;
  localparam logic [11:0] IDX_P3        = 12'h006;
  localparam logic [11:0] IDX_PULLUP_CONTROL_FIRST     = 12'hef0;
  localparam logic [11:0] IDX_PULLUP_CONTROL_SECOND     = 12'hef1;
  localparam logic [11:0] IDX_DISP_MODE = 12'hef4;
  localparam logic [11:0] IDX_NONE      = 12'hfff;
  localparam logic [11:0] IDX_DIR_STEP  = 12'h001;

  // Port slots 0..7 are ports 0, 2, 4, 5, 6, 7, 8 and 9.
  localparam logic [NPORT-1:0][11:0] PORT_IDX =
    {12'h012, 12'h010, 12'h00e, 12'h00c, 12'h00a, 12'h008, 12'h004, 12'h000};
  localparam logic [NPORT-1:0][7:0] WIDTH_MASK =
    {8'h03, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h7f, 8'hff, 8'hff};
  // High-voltage pins drive high only; open-drain pins drive low only.
  localparam logic [NPORT-1:0][7:0] HV_MASK =
    {8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
  localparam logic [NPORT-1:0][7:0] ND_MASK =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h00};
  localparam logic [NPORT-1:0][7:0] PU_MASK =
    {8'h03, 8'hf0, 8'hff, 8'h3e, 8'hff, 8'h00, 8'h00, 8'h00};
  // Bit of {second, first} pull-up register that controls each port.
  localparam logic [NPORT-1:0][3:0] PU_SEL =
    {4'h9, 4'h8, 4'h2, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0};

  localparam int WEAK_BIT = 7;

  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR   = 8'h00;
  localparam logic [7:0] RST_PULL  = 8'h00;
  localparam logic [7:0] RST_MODE  = 8'h00;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pull_en;
  } bpp_pin_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] idx;
  } bpp_aphase_type;

endpackage

// file: rtl/bpp_port.sv
// Register access over AHB-Lite was left to the implementer.
module bpp_port #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input  wire logic                                        core_clk,
  input  wire logic                                        reset_n,
  // AHB-Lite slave
  input  wire logic                                        hsel,
  input  wire logic [ADDR_W-1:0]                           haddr,
  input  wire logic [1:0]                                  htrans,
  input  wire logic                                        hwrite,
  input  wire logic [2:0]                                  hsize,
  input  wire logic [31:0]                                 hwdata,
  input  wire logic                                        hready,
  output logic                                             hreadyout,
  output logic [31:0]                                      hrdata,
  output logic                                             hresp,
  // Bidirectional port pins
  input  wire logic [bpp_pkg::NPORT-1:0][7:0]              pin_in,
  output bpp_pkg::bpp_pin_type [bpp_pkg::NPORT-1:0]        port_pins,
  // Output-only display ports and drive strength
  output logic [7:0]                                       display_segment_output_p1,
  output logic [7:0]                                       display_segment_output_p3,
  output logic                                             weak_drive
);

  // The unmapped test reads haddr[ADDR_W-1:14], so at least one bit above bit 13 must exist.
  if (ADDR_W < 15)
  begin : g_chk
    $error("ADDR_W must be at least 15");
  end

  localparam int NP = bpp_pkg::NPORT;

  logic [NP-1:0][7:0]               latch_r;
  logic [NP-1:0][7:0]               latch_nxt;
  logic [NP-1:0][7:0]               dir_r;
  logic [NP-1:0][7:0]               dir_nxt;
  logic [7:0]                       p1_r;
  logic [7:0]                       p1_nxt;
  logic [7:0]                       p3_r;
  logic [7:0]                       p3_nxt;
  logic [7:0]                       pullup_control_first_r;
  logic [7:0]                       pullup_control_first_nxt;
  logic [7:0]                       pullup_control_second_r;
  logic [7:0]                       pullup_control_second_nxt;
  logic [7:0]                       mode_r;
  logic [7:0]                       mode_nxt;
  bpp_pkg::bpp_aphase_type          aph_r;
  bpp_pkg::bpp_aphase_type          aph_nxt;
  logic [31:0]                      hrdata_r;
  logic [31:0]                      hrdata_nxt;
  logic [NP-1:0][7:0]               s1_r;
  logic [NP-1:0][7:0]               s2_r;
  logic [NP-1:0][7:0]               s3_r;
  logic [NP-1:0][7:0]               filt_r;
  logic [NP-1:0][7:0]               filt_nxt;
  bpp_pkg::bpp_pin_type [NP-1:0]    pins_r;
  bpp_pkg::bpp_pin_type [NP-1:0]    pins_nxt;
  logic                             rst_done_r;

  // Register file and bus answer; writes land at the end of the data phase.
  always_comb
  begin
    logic [7:0] rd;
    rd        = 8'h00;
    latch_nxt = latch_r;
    dir_nxt   = dir_r;
    p1_nxt    = p1_r;
    p3_nxt    = p3_r;
    pullup_control_first_nxt = pullup_control_first_r;
    pullup_control_second_nxt = pullup_control_second_r;
    mode_nxt  = mode_r;
    aph_nxt.valid = hsel & hready & htrans[1];
    aph_nxt.write = hwrite;
    aph_nxt.idx   = (haddr[ADDR_W-1:14] == '0) ? haddr[13:2] : bpp_pkg::IDX_NONE;
    if (aph_r.valid && aph_r.write)
    begin
      for (int p = 0; p < NP; p++)
      begin
        if (aph_r.idx == bpp_pkg::PORT_IDX[p])
          latch_nxt[p] = hwdata[7:0] & bpp_pkg::WIDTH_MASK[p];
        if (aph_r.idx == bpp_pkg::PORT_IDX[p] + bpp_pkg::IDX_DIR_STEP)
          dir_nxt[p] = hwdata[7:0] & bpp_pkg::WIDTH_MASK[p];
      end
      case (aph_r.idx)
        bpp_pkg::IDX_P1:        p1_nxt    = hwdata[7:0];
        bpp_pkg::IDX_P3:        p3_nxt    = hwdata[7:0];
        bpp_pkg::IDX_PULLUP_CONTROL_FIRST:     pullup_control_first_nxt = hwdata[7:0];
        bpp_pkg::IDX_PULLUP_CONTROL_SECOND:     pullup_control_second_nxt = hwdata[7:0];
        bpp_pkg::IDX_DISP_MODE: mode_nxt  = hwdata[7:0];
        default:                ;
      endcase
    end
    // Reads see a write that completes in the same cycle.
    for (int p = 0; p < NP; p++)
    begin
      // latch for outputs, pin level for inputs
      if (aph_nxt.idx == bpp_pkg::PORT_IDX[p])
        rd = ((dir_nxt[p] & latch_nxt[p]) | (~dir_nxt[p] & filt_r[p])) & bpp_pkg::WIDTH_MASK[p];
      if (aph_nxt.idx == bpp_pkg::PORT_IDX[p] + bpp_pkg::IDX_DIR_STEP)
        rd = dir_nxt[p];
    end
    case (aph_nxt.idx)
      bpp_pkg::IDX_P1:        rd = p1_nxt;
      bpp_pkg::IDX_P3:        rd = p3_nxt;
      bpp_pkg::IDX_PULLUP_CONTROL_FIRST:     rd = pullup_control_first_nxt;
      bpp_pkg::IDX_PULLUP_CONTROL_SECOND:     rd = pullup_control_second_nxt;
      bpp_pkg::IDX_DISP_MODE: rd = mode_nxt;
      default:                ;
    endcase
    hrdata_nxt = (aph_nxt.valid && !hwrite) ? {24'h000000, rd} : hrdata_r;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latch_r    <= {NP{bpp_pkg::RST_LATCH}};
      dir_r      <= {NP{bpp_pkg::RST_DIR}};
      p1_r       <= bpp_pkg::RST_LATCH;
      p3_r       <= bpp_pkg::RST_LATCH;
      pullup_control_first_r    <= bpp_pkg::RST_PULL;
      pullup_control_second_r    <= bpp_pkg::RST_PULL;
      mode_r     <= bpp_pkg::RST_MODE;
      aph_r      <= '0;
      hrdata_r   <= 32'h00000000;
      rst_done_r <= 1'b0;
    end
    else
    begin
      latch_r    <= latch_nxt;
      dir_r      <= dir_nxt;
      p1_r       <= p1_nxt;
      p3_r       <= p3_nxt;
      pullup_control_first_r    <= pullup_control_first_nxt;
      pullup_control_second_r    <= pullup_control_second_nxt;
      mode_r     <= mode_nxt;
      aph_r      <= aph_nxt;
      hrdata_r   <= hrdata_nxt;
      rst_done_r <= 1'b1;
    end
  end

  // Pin level filter: a change counts once stages two and three agree.
  always_comb
  begin
    filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      filt_r <= '0;
    end
    else
    begin
      s1_r   <= pin_in;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // Pin drivers follow the registers in the same edge as the write.
  always_comb
  begin
    logic [15:0] pull_all;
    logic [7:0]  cm;
    logic [7:0]  dr;
    cm       = 8'h00;
    dr       = 8'h00;
    pull_all = {pullup_control_second_nxt, pullup_control_first_nxt};
    for (int p = 0; p < NP; p++)
    begin
      cm = ~bpp_pkg::HV_MASK[p] & ~bpp_pkg::ND_MASK[p];
      dr = dir_nxt[p] & bpp_pkg::WIDTH_MASK[p];
      pins_nxt[p].oe = (dr & cm) | (dr & latch_nxt[p] & bpp_pkg::HV_MASK[p])
                     | (dr & ~latch_nxt[p] & bpp_pkg::ND_MASK[p]);
      pins_nxt[p].dout = (latch_nxt[p] & cm) | bpp_pkg::HV_MASK[p];
      pins_nxt[p].pull_en = {8{pull_all[bpp_pkg::PU_SEL[p]]}} & bpp_pkg::PU_MASK[p] & ~dr;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      pins_r <= '0;
    else
      pins_r <= pins_nxt;
  end

  assign port_pins                 = pins_r;
  assign display_segment_output_p1 = p1_r;
  assign display_segment_output_p3 = p3_r;
  assign weak_drive                = mode_r[bpp_pkg::WEAK_BIT];
  assign hrdata                    = hrdata_r;
  assign hreadyout                 = rst_done_r | ~rst_done_r;
  assign hresp                     = 1'b0;

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic float_bad;
  logic pull_bad;
  always_comb
  begin
    float_bad = 1'b0;
    pull_bad  = 1'b0;
    for (int p = 0; p < NP; p++)
    begin
      float_bad = float_bad | (|(pins_r[p].oe & ~dir_r[p]));
      pull_bad  = pull_bad | (|(pins_r[p].pull_en & (dir_r[p] | ~bpp_pkg::PU_MASK[p])));
    end
  end

  sequence s_dir_wr;
    aph_r.valid && aph_r.write && aph_r.idx == bpp_pkg::PORT_IDX[2] + bpp_pkg::IDX_DIR_STEP;
  endsequence

  sequence s_rd0;
    aph_nxt.valid && !hwrite && aph_nxt.idx == bpp_pkg::PORT_IDX[0];
  endsequence

  AST_DIR_WRITE: assert property (s_dir_wr |=> dir_r[2] == ($past(hwdata[7:0]) & bpp_pkg::WIDTH_MASK[2]))
    else $error("direction write not stored");
  AST_DIR_KEEPS_LATCH: assert property (s_dir_wr |=> latch_r[2] == $past(latch_r[2]))
    else $error("direction write changed the latch");
  AST_READ_MUX: assert property (s_rd0 |=> hrdata_r[7:0] == (($past(dir_nxt[0]) & $past(latch_nxt[0]))
      | (~$past(dir_nxt[0]) & $past(filt_r[0]))))
    else $error("port read returned wrong source");
  AST_INPUT_FLOAT: assert property (!float_bad)
    else $error("input pin driven");
  AST_FILTER: assert property ((s2_r[3][0] == s3_r[3][0]) |=> filt_r[3][0] == $past(s3_r[3][0]))
    else $error("pin filter missed an agreed level");
  AST_HV_GATE: assert property (pins_r[0].oe == (dir_r[0] & latch_r[0]))
    else $error("high-voltage driver not gated by latch");
  AST_WEAK: assert property (aph_r.valid && aph_r.write && aph_r.idx == bpp_pkg::IDX_DISP_MODE
      |=> weak_drive == $past(hwdata[7]))
    else $error("drive strength not updated");
  AST_RESET_CLEAN: assert property ($rose(rst_done_r) |-> !weak_drive && dir_r == '0
      && pullup_control_first_r == 8'h00 && p1_r == 8'h00 ##1 hrdata_r[31:8] == 24'h000000)
    else $error("reset state wrong");
  AST_PULL_GATE: assert property (!pull_bad)
    else $error("pull-up on where not allowed");
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not OKAY");

endmodule

// file: testbench/bpp_board.sv
module bpp_board (
  // Clock
  input  wire logic                                  core_clk,
  // Device pins
  input  wire bpp_pkg::bpp_pin_type [bpp_pkg::NPORT-1:0] port_pins,
  // Board drive
  input  wire logic [bpp_pkg::NPORT-1:0][7:0]        ext_en,
  input  wire logic [bpp_pkg::NPORT-1:0][7:0]        ext_val,
  output logic [bpp_pkg::NPORT-1:0][7:0]             pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;

  // A floating pin shows a pattern that changes every cycle.
  always @(posedge core_clk)
    flip <= ~flip;

  // The device's own drive wins; high-voltage pins have pull-downs.
  always_comb
    for (int s = 0; s < bpp_pkg::NPORT; s++)
      for (int b = 0; b < 8; b++)
        pin_in[s][b] = port_pins[s].oe[b] ? port_pins[s].dout[b] : ext_en[s][b] ? ext_val[s][b] :
                       port_pins[s].pull_en[b] ? 1'b1 : bpp_pkg::HV_MASK[s][b] ? 1'b0 : flip;
endmodule

// file: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, weak_drive;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [7:0]  disp_p1, disp_p3, rd;
  logic [bpp_pkg::NPORT-1:0][7:0] pin_in, ext_en, ext_val;
  bpp_pkg::bpp_pin_type [bpp_pkg::NPORT-1:0] pins;
  int n_fail = 0;
  int compares = 0;

  assign hready = hreadyout;

  bpp_port i_bpp_port (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pin_in(pin_in), .port_pins(pins), .display_segment_output_p1(disp_p1),
    .display_segment_output_p3(disp_p3), .weak_drive(weak_drive));
  bpp_board i_bpp_board (.core_clk(core_clk), .port_pins(pins), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task end_sim;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task bus(input logic w, input logic [11:0] idx, input logic [7:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'h0};
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
    #1;
  endtask

  task wr(input logic [11:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task rdchk(input string nm, input logic [11:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask

  task t_reset;
    rdchk("mode", bpp_pkg::IDX_DISP_MODE, 8'h00);
    chk("weak", weak_drive, 8'h00);
    chk("disp1", disp_p1, 8'h00);
    for (int s = 0; s < bpp_pkg::NPORT; s++)
    begin
      chk("oe", pins[s].oe, 8'h00);
      chk("pull", pins[s].pull_en, 8'h00);
    end
    $display("test reset done");
  endtask

  task t_width;
    for (int s = 0; s < bpp_pkg::NPORT; s++)
    begin
      wr(bpp_pkg::PORT_IDX[s] + bpp_pkg::IDX_DIR_STEP, 8'hff);
      rdchk("dir", bpp_pkg::PORT_IDX[s] + bpp_pkg::IDX_DIR_STEP, bpp_pkg::WIDTH_MASK[s]);
      chk("oe", pins[s].oe, bpp_pkg::WIDTH_MASK[s] & ~bpp_pkg::HV_MASK[s]);
      wr(bpp_pkg::PORT_IDX[s] + bpp_pkg::IDX_DIR_STEP, 8'h00);
    end
    $display("test width done");
  endtask

  task t_dir;
    ext_en[3] <= 8'hf0;
    ext_val[3] <= 8'h3c;
    wr(12'h00a, 8'ha5);
    chk("oe", pins[3].oe, 8'h00);
    wr(12'h00b, 8'h0f);
    chk("oe", pins[3].oe, 8'h0f);
    chk("oe4", pins[4].oe, 8'h00);
    chk("dout", pins[3].dout, 8'ha5);
    repeat (6) @(posedge core_clk);
    rdchk("read", 12'h00a, 8'h35);
    $display("test direction done");
  endtask

  task t_pull;
    ext_en[3] <= 8'h00;
    wr(bpp_pkg::IDX_PULLUP_CONTROL_FIRST, 8'hff);
    wr(bpp_pkg::IDX_PULLUP_CONTROL_SECOND, 8'hff);
    chk("pull", pins[3].pull_en, 8'hf0);
    chk("pull4", pins[4].pull_en, 8'h3e);
    for (int s = 0; s < 3; s++)
      chk("pull", pins[s].pull_en, 8'h00);
    repeat (6) @(posedge core_clk);
    rdchk("read", 12'h00a, 8'hf5);
    wr(12'h00b, 8'hff);
    chk("pull", pins[3].pull_en, 8'h00);
    $display("test pull-up done");
  endtask

  task t_hv;
    wr(bpp_pkg::IDX_P1, 8'h5a);
    chk("disp1", disp_p1, 8'h5a);
    wr(12'h000, 8'h0f);
    wr(12'h001, 8'hff);
    chk("oe", pins[0].oe, 8'h0f);
    chk("dout", pins[0].dout, 8'hff);
    rdchk("read0", 12'h000, 8'h0f);
    wr(bpp_pkg::IDX_P3, 8'ha5);
    chk("disp3", disp_p3, 8'ha5);
    rdchk("p3", bpp_pkg::IDX_P3, 8'ha5);
    wr(bpp_pkg::IDX_DISP_MODE, 8'h80);
    chk("weak", weak_drive, 8'h01);
    rdchk("mode", bpp_pkg::IDX_DISP_MODE, 8'h80);
    wr(bpp_pkg::IDX_NONE, 8'hff);
    rdchk("unmapped", bpp_pkg::IDX_NONE, 8'h00);
    chk("hresp", hresp, 8'h00);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("oe", pins[0].oe, 8'h00);
    chk("disp1", disp_p1, 8'h00);
    chk("disp3", disp_p3, 8'h00);
    chk("weak", weak_drive, 8'h00);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rdchk("mode", bpp_pkg::IDX_DISP_MODE, 8'h00);
    rdchk("dir", 12'h00b, 8'h00);
    $display("test high voltage done");
  endtask

  initial
  begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    ext_en = '0;
    ext_val = '0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1;
    t_reset;
    t_width;
    t_dir;
    t_pull;
    t_hv;
    end_sim;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_sim;
  end
endmodule
